// File: hdl/sasp_top.sv
`timescale 1ns/1ns
`include "sasp_regs.svh"
// Behaviour
// - one stereo port, master or slave
// - master drives clock/select; slave takes them
// - data output always driven
// - 16-bit words, msb first, i2s aligned
// - msb one bit clock after select edge
// - left when select low, right high
// - data changes on falling bit clock
// - master bit clock 48k x 32 = 1.536 MHz
// - master clock from n/m fractional divider
// - slave works up to 3.072 MHz
module sasp_top
	import sasp_pkg::*;
(
	input  wire logic                   clock,         // system clock, 100 MHz
	input  wire logic                   srst,          // sync reset, high
	input  wire logic                   ce,            // clock enable, freezes all
	input  wire sasp_pkg::sasp_mode_t   mode,          // master or slave role
	input  wire logic [`SASP_DIV_W-1:0] div_n,         // divider numerator
	input  wire logic [`SASP_DIV_W-1:0] div_m,         // divider denominator
	input  wire logic [15:0]            left_data,     // left sample
	input  wire logic [15:0]            right_data,    // right sample
	input  wire logic                   sample_valid,  // new stereo pair offered
	output logic                        sample_ready,  // pair taken the cycle before
	input  wire logic                   bclk_i,        // bit clock pin in
	output logic                        bclk_o,        // bit clock pin out
	output logic                        bclk_oe,       // bit clock drive enable
	input  wire logic                   wsel_i,        // word select pin in
	output logic                        wsel_o,        // word select pin out
	output logic                        wsel_oe,       // word select drive enable
	output logic                        audio_serial_data_out // serial data out
);
	import sasp_pkg::*;

	//------------------------------------------------------------
	// master bit clock generation
	//------------------------------------------------------------
	logic is_master;  // role decode
	logic div_tick;   // half-period step

	assign is_master = (mode == SASP_MASTER);

	// pulse rate 2x bclk; defaults give 3.072 MHz pulses, 1.536 MHz bclk
	sasp_frac_div u_div (
		.clock (clock),
		.srst  (srst),
		.ce    (ce),
		.run   (is_master),
		.div_n (div_n),
		.div_m (div_m),
		.tick  (div_tick)
	);

	//------------------------------------------------------------
	// slave pin sampling and edge detection
	//------------------------------------------------------------
	logic sync1_ff, sync2_ff, sync3_ff;    // bit clock history
	logic wsy1_ff, wsy2_ff, wsy3_ff;       // word select history
	logic nxt_sync1, nxt_sync2, nxt_sync3;
	logic nxt_wsy1, nxt_wsy2, nxt_wsy3;

	// two stages plus history; safe since 3.072 MHz gives 16 clocks per half
	always_comb begin
		nxt_sync1 = bclk_i;
		nxt_sync2 = sync1_ff;
		nxt_sync3 = sync2_ff;
		nxt_wsy1  = wsel_i;
		nxt_wsy2  = wsy1_ff;
		nxt_wsy3  = wsy2_ff;
	end

	// register only
	always_ff @(posedge clock) begin
		if (srst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			sync3_ff <= 1'b0;
			wsy1_ff  <= 1'b0;
			wsy2_ff  <= 1'b0;
			wsy3_ff  <= 1'b0;
		end else if (ce) begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			sync3_ff <= nxt_sync3;
			wsy1_ff  <= nxt_wsy1;
			wsy2_ff  <= nxt_wsy2;
			wsy3_ff  <= nxt_wsy3;
		end
	end

	//------------------------------------------------------------
	// frame engine
	//------------------------------------------------------------
	logic                   bclk_ff, nxt_bclk;     // master bit clock level
	logic                   ws_ff, nxt_ws;         // master word select level
	logic                   prev_ws_ff, nxt_prev_ws; // select seen at last fall
	logic [3:0]             bit_cnt_ff, nxt_bit_cnt; // master bit in word
	logic [15:0]            shreg_ff, nxt_shreg;   // outgoing word
	logic [15:0]            rhold_ff, nxt_rhold;   // right word waiting
	logic [15:0]            lhold_ff, nxt_lhold;   // next left word
	logic                   sdo_ff, nxt_sdo;       // data pin
	logic                   ready_ff, nxt_ready;   // pair accepted pulse
	logic                   fall;                  // falling bit clock event
	logic                   cur_ws;                // word select at this fall

	// one falling event per bit in either role
	always_comb begin
		if (is_master) begin
			fall   = div_tick && bclk_ff;
			cur_ws = ws_ff;
		end else begin
			fall   = sync3_ff && !sync2_ff;
			// select taken beside the last high clock sample: the far master moves
			// select on this same fall, so the msb has to wait for the next one
			cur_ws = wsy3_ff;
		end
	end

	// advance on each falling edge; underrun resends last pair
	always_comb begin
		nxt_bclk    = bclk_ff;
		nxt_ws      = ws_ff;
		nxt_prev_ws = prev_ws_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shreg   = shreg_ff;
		nxt_rhold   = rhold_ff;
		nxt_lhold   = lhold_ff;
		nxt_sdo     = sdo_ff;
		nxt_ready   = 1'b0;
		// take a new pair whenever valid unless one was taken the cycle before; holds are overwritten
		if (sample_valid && !ready_ff) begin
			nxt_lhold = left_data;
			nxt_rhold = right_data;
			nxt_ready = 1'b1;
		end
		if (is_master && div_tick) begin
			nxt_bclk = !bclk_ff;
		end else if (!is_master) begin
			nxt_bclk = 1'b0;
		end
		if (fall) begin
			// master select flips on the same fall that sends the 16th bit of each word
			if (is_master) begin
				nxt_bit_cnt = bit_cnt_ff + 4'h1;
				if (bit_cnt_ff == `SASP_MSB_IDX) begin
					nxt_ws = !ws_ff;
				end
			end
			nxt_prev_ws = cur_ws;
			if (cur_ws != prev_ws_ff) begin
				// select changed one bit ago, so msb goes out now
				nxt_shreg = cur_ws ? rhold_ff : lhold_ff;
				nxt_sdo   = nxt_shreg[15];
				nxt_shreg = {nxt_shreg[14:0], 1'b0};
			end else begin
				// msb first, changed on the falling edge
				nxt_sdo   = shreg_ff[15];
				nxt_shreg = {shreg_ff[14:0], 1'b0};
			end
		end
	end

	// register only
	always_ff @(posedge clock) begin
		if (srst) begin
			bclk_ff    <= 1'b0;
			ws_ff      <= 1'b0;
			prev_ws_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
			shreg_ff   <= 16'h0000;
			rhold_ff   <= 16'h0000;
			lhold_ff   <= 16'h0000;
			sdo_ff     <= 1'b0;
			ready_ff   <= 1'b0;
		end else if (ce) begin
			bclk_ff    <= nxt_bclk;
			ws_ff      <= nxt_ws;
			prev_ws_ff <= nxt_prev_ws;
			bit_cnt_ff <= nxt_bit_cnt;
			shreg_ff   <= nxt_shreg;
			rhold_ff   <= nxt_rhold;
			lhold_ff   <= nxt_lhold;
			sdo_ff     <= nxt_sdo;
			ready_ff   <= nxt_ready;
		end
	end

	//------------------------------------------------------------
	// pin enables
	//------------------------------------------------------------
	logic oe_ff, nxt_oe; // drive enable for clock and select

	// released in slave mode so the far party owns the lines
	always_comb begin
		nxt_oe = is_master;
	end

	// register only
	always_ff @(posedge clock) begin
		if (srst) begin
			oe_ff <= 1'b0;
		end else if (ce) begin
			oe_ff <= nxt_oe;
		end
	end

	//------------------------------------------------------------
	// outputs, all from flip-flops
	//------------------------------------------------------------
	assign bclk_o                = bclk_ff;
	assign bclk_oe               = oe_ff;
	assign wsel_o                = ws_ff;
	assign wsel_oe               = oe_ff;
	assign audio_serial_data_out = sdo_ff;
	assign sample_ready          = ready_ff;
	// far receiver samples on rising edge, data stable half a period
endmodule

// File: hdl/sasp_regs.svh
`ifndef SASP_REGS_SVH
`define SASP_REGS_SVH
//------------------------------------------------------------
// word and frame layout
//------------------------------------------------------------
`define SASP_WORD_BITS      16
`define SASP_FRAME_BITS     32
`define SASP_CNT_W          5
`define SASP_MSB_IDX        4'hf
//------------------------------------------------------------
// timing figures
//------------------------------------------------------------
`define SASP_CLK_HZ         100000000
`define SASP_FRAME_HZ       48000
`define SASP_BCLK_HZ        (`SASP_FRAME_HZ * `SASP_FRAME_BITS)
`define SASP_SLAVE_MAX_HZ   3072000
// fastest slave bit clock gives at least this many system clocks per half period
`define SASP_SLAVE_HALF_CYC (`SASP_CLK_HZ / (2 * `SASP_SLAVE_MAX_HZ))
//------------------------------------------------------------
// divider defaults: 2 * bclk / clk = 3072000 / 100000000 = 96 / 3125
//------------------------------------------------------------
`define SASP_DIV_W          16
`define SASP_DIV_N_RST      16'h0060
`define SASP_DIV_M_RST      16'h0c35
`endif

// File: hdl/sasp_pkg.sv
package sasp_pkg;
	// link role of the port
	typedef enum logic {
		SASP_SLAVE,
		SASP_MASTER
	} sasp_mode_t;
	// channel being shifted out
	typedef enum logic {
		SASP_LEFT,
		SASP_RIGHT
	} sasp_chan_t;
endpackage

// File: hdl/sasp_frac_div.sv
`timescale 1ns/1ns
`include "sasp_regs.svh"
// fractional n/m accumulator: pulses n times every m enabled cycles
module sasp_frac_div (
	input  wire logic                   clock,  // system clock
	input  wire logic                   srst,   // sync reset, high
	input  wire logic                   ce,     // clock enable
	input  wire logic                   run,    // divider active
	input  wire logic [`SASP_DIV_W-1:0] div_n,  // numerator
	input  wire logic [`SASP_DIV_W-1:0] div_m,  // denominator
	output logic                        tick    // half-period step pulse
);
	//------------------------------------------------------------
	// accumulator
	//------------------------------------------------------------
	logic [`SASP_DIV_W:0] acc_ff;  // phase accumulator
	logic [`SASP_DIV_W:0] nxt_acc; // next phase
	logic                 tick_ff; // registered pulse
	logic                 nxt_tick;
	logic [`SASP_DIV_W:0] sum;     // phase plus step

	// add n each cycle, wrap at m; jitter is one system clock at most
	always_comb begin
		sum      = acc_ff + {1'b0, div_n};
		nxt_acc  = acc_ff;
		nxt_tick = 1'b0;
		if (!run) begin
			nxt_acc = '0;
		end else if (sum >= {1'b0, div_m}) begin
			nxt_acc  = sum - {1'b0, div_m};
			nxt_tick = 1'b1;
		end else begin
			nxt_acc = sum;
		end
	end

	// register only
	always_ff @(posedge clock) begin
		if (srst) begin
			acc_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (ce) begin
			acc_ff  <= nxt_acc;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule

// File: tb/sasp_top_assertions.sv
`timescale 1ns/1ns
`include "sasp_regs.svh"
module sasp_chk
	import sasp_pkg::*;
(
	input wire logic	clock,	// sys clock
	input wire logic	srst,	// sync reset
	input wire logic	ce,	// enable
	input wire sasp_pkg::sasp_mode_t	mode,	// role
	input wire logic [`SASP_DIV_W-1:0]	div_n,	// numerator
	input wire logic [`SASP_DIV_W-1:0]	div_m,	// denominator
	input wire logic [15:0]	left_data,	// left word
	input wire logic [15:0]	right_data,	// right word
	input wire logic	sample_valid,	// pair offered
	input wire logic	sample_ready,	// pair taken
	input wire logic	bclk_i,	// clock pin in
	input wire logic	bclk_o,	// clock pin out
	input wire logic	bclk_oe,	// clock drive
	input wire logic	wsel_i,	// select pin in
	input wire logic	wsel_o,	// select pin out
	input wire logic	wsel_oe,	// select drive
	input wire logic	audio_serial_data_out	// data
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (srst);
	//----------------------------------------
	// clocks since the last bit clock fall
	//----------------------------------------
	logic [6:0]	pcnt_ff, nxt_pcnt;	// fall spacing
	logic	seen_ff, nxt_seen, bprev_ff;	// first fall ignored: phase unknown
	always_comb begin
		nxt_pcnt = pcnt_ff + 7'h01;
		nxt_seen = seen_ff;
		if (srst || !bclk_oe) begin
			nxt_pcnt = 7'h00;
			nxt_seen = 1'b0;
		end else if (bprev_ff && !bclk_o) begin
			nxt_pcnt = 7'h00;
			nxt_seen = 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		pcnt_ff <= nxt_pcnt;
		seen_ff <= nxt_seen;
		bprev_ff <= bclk_o;
	end
	//----------------------------------------
	// properties
	//----------------------------------------
	a_master_drives: assert property ((mode == SASP_MASTER) [*4] |-> bclk_oe && wsel_oe)
		else $error("master not driving clock and select");
	a_slave_listens: assert property ((mode == SASP_SLAVE) [*4] |-> !bclk_oe && !wsel_oe)
		else $error("slave driving clock or select");
	a_ready_single: assert property (sample_ready |=> !sample_ready)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (sample_ready |-> $past(sample_valid))
		else $error("ready without valid");
	a_data_on_fall: assert property (bclk_oe && $past(bclk_oe) && $changed(audio_serial_data_out) |-> $fell(bclk_o))
		else $error("data moved off a falling edge");
	a_wsel_on_fall: assert property (bclk_oe && $past(bclk_oe) && $changed(wsel_o) |-> $fell(bclk_o))
		else $error("select moved off a falling edge");
	a_bclk_rate: assert property (bclk_oe && seen_ff && bprev_ff && !bclk_o |-> pcnt_ff inside {7'h40, 7'h41})
		else $error("bit clock period wrong");
	a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0) srst |=> !sample_ready && !bclk_oe)
		else $error("outputs active after reset");
	c_take: cover property (sample_ready);
	c_fall: cover property ($fell(bclk_o) && bclk_oe);
	c_word: cover property ($rose(wsel_o));
endmodule
bind sasp_top sasp_chk chk_u (.clock(clock), .srst(srst), .ce(ce), .mode(mode), .div_n(div_n), .div_m(div_m),
	.left_data(left_data), .right_data(right_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
	.bclk_i(bclk_i), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wsel_i(wsel_i), .wsel_o(wsel_o), .wsel_oe(wsel_oe),
	.audio_serial_data_out(audio_serial_data_out));

// File: tb/sasp_codec_model.sv
`timescale 1ns/1ns
// far-side codec: receives words, drives clock and select as slave master
module sasp_codec_model (
	input wire logic	run,	// make clock and select
	input wire logic [9:0]	half_ns,	// half bit period
	input wire logic	bclk,	// clock wire
	input wire logic	wsel,	// select wire
	input wire logic	sdo,	// data wire
	output logic	bclk_drv,	// clock we drive
	output logic	wsel_drv,	// select we drive
	output logic [15:0]	got_left,	// last left word
	output logic [15:0]	got_right,	// last right word
	output int	n_words	// words received
);
	logic [15:0]	shift;	// incoming bits
	logic [4:0]	nbit;	// bits since select edge
	logic	ws_prev;	// select at last rising edge
	initial begin
		{shift, nbit, ws_prev, n_words, bclk_drv, wsel_drv} = '0;
		forever begin
			wait (run);
			// clock idles low while run is low; frames run back to back, half period half_ns
			for (int i = 0; i < 32; i++) begin
				#(half_ns) bclk_drv = 1'b1;
				#(half_ns) bclk_drv = 1'b0;
				if (i == 15 || i == 31) wsel_drv = ~wsel_drv;
			end
		end
	end
	// sample on rising clock; select edge closes the word, partial words dropped
	always @(posedge bclk) begin
		if (wsel !== ws_prev) begin
			if (nbit == 5'h0f) begin
				if (ws_prev) got_right = {shift[14:0], sdo};
				else got_left = {shift[14:0], sdo};
				n_words++;
			end
			nbit = 5'h00;
		end else nbit++;
		shift = {shift[14:0], sdo};
		ws_prev = wsel;
	end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
`include "sasp_regs.svh"
module testbench;
	import sasp_pkg::*;
	logic clock, srst, sample_valid, sample_ready, bclk_o, bclk_oe, wsel_o, wsel_oe, sdo, bclk_drv, wsel_drv, run;
	logic [15:0] left_data, right_data, got_left, got_right;
	logic [9:0] half_ns;
	sasp_mode_t mode;
	int n_words, n_fail, check_count;
	wire bclk_w = bclk_oe ? bclk_o : bclk_drv;	// shared clock wire
	wire wsel_w = wsel_oe ? wsel_o : wsel_drv;	// shared select wire
	sasp_top dut_u (.clock(clock), .srst(srst), .ce(1'b1), .mode(mode), .div_n(`SASP_DIV_N_RST),
		.div_m(`SASP_DIV_M_RST), .left_data(left_data), .right_data(right_data), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wsel_i(wsel_w),
		.wsel_o(wsel_o), .wsel_oe(wsel_oe), .audio_serial_data_out(sdo));
	sasp_codec_model peer_u (.run(run), .half_ns(half_ns), .bclk(bclk_w), .wsel(wsel_w), .sdo(sdo),
		.bclk_drv(bclk_drv), .wsel_drv(wsel_drv), .got_left(got_left), .got_right(got_right), .n_words(n_words));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input bit bad, input string m);
		check_count++;
		if (bad) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// offer a at c0, b at c1: c1 ready, c2 refused, c3 takes b
	task t_offer(input logic [31:0] a, input logic [31:0] b);
		sample_valid = 1'b1;
		{left_data, right_data} = a;
		@(negedge clock) chk(sample_ready !== 1'b1, "no take");
		{left_data, right_data} = b;
		@(negedge clock) chk(sample_ready !== 1'b0, "no refusal");
		@(negedge clock) chk(sample_ready !== 1'b1, "no second take");
		sample_valid = 1'b0;
	endtask
	// bounded wait for words, then the latest pair must be on the line
	task t_words(input logic [31:0] p);
		int k;
		k = n_words + 5;
		for (int i = 0; i < 30000 && n_words < k; i++) @(negedge clock);
		chk(n_words < k, "no words");
		if (n_words < k) conclude();
		chk({got_left, got_right} !== p, "serial pair");
	endtask
	task t_master;
		mode = SASP_MASTER;
		t_offer(32'h1234_8765, 32'ha5c3_3c5a);
		chk({bclk_oe, wsel_oe} !== 2'b11, "master drive");
		t_words(32'ha5c3_3c5a);
	endtask
	task t_slave(input logic [9:0] h, input logic [31:0] p);
		mode = SASP_SLAVE;
		half_ns = h;
		run = 1'b1;
		t_offer(~p, p);
		chk({bclk_oe, wsel_oe} !== 2'b00, "slave drive");
		t_words(p);
		run = 1'b0;
	endtask
	initial begin
		{srst, sample_valid, run, left_data, right_data} = {3'b100, 32'h0000_0000};
		mode = SASP_MASTER;
		// even half periods keep the peer's pin edges off the sampling clock edge
		half_ns = 10'h0a4;
		repeat (20) @(negedge clock);
		chk({sample_ready, bclk_oe, sdo} !== 3'b000, "reset outputs");
		srst = 1'b0;
		@(negedge clock);
		t_master;
		t_slave(10'h0a4, 32'h8001_7ffe);
		t_slave(10'h146, 32'h00ff_f00f);
		t_master;
		conclude();
	end
endmodule
